//--- hdl/clk_dist_defs.vh
`ifndef CLK_DIST_DEFS_VH
`define CLK_DIST_DEFS_VH
// ****************************************
// Register byte offsets
// ****************************************
`define OFF_CTRL    12'h000
`define OFF_FBDIV   12'h004
`define OFF_REFDIV  12'h008
`define OFF_SDIV    12'h00C
`define OFF_ODIV    12'h010
`define OFF_ODEL    12'h014
`define OFF_REFMHZ  12'h018
`define OFF_STATUS  12'h01C
// ****************************************
// Control fields
// ****************************************
`define CTRL_PLL    0
`define CTRL_OEN    1
`define CTRL_RUN_LO 2
`define CTRL_RUN_HI 3
`define CTRL_LOAD   4
`define RUN_GATE    2'h1
// ****************************************
// Reset values and limits
// ****************************************
`define RST_FBDIV   16'h0064
`define RST_REFDIV  16'h0005
`define RST_SDIV    16'h0008
`define RST_ODIV    16'h0008
`define RST_ODEL    16'h0000
`define RST_REFMHZ  16'h0032
`define VCXO_MHZ    32'h000001F4
`define FB_SCALE    32'h00000002
`define SDIV_MIN    16'h0008
`endif

//--- hdl/clk_dist.v
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "clk_dist_defs.vh"
// Clock distribution and board alignment control. The APB side stands for
// the fixed oscillator domain; pclk also stands in for the VCXO tick.
module clk_dist #(
    parameter TRIG_LATENCY = 4            // Daisy-chain regeneration delay
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        source_select_switch,  // 1: external reference; only read back in status, selects nothing
    input  wire        shared_external_clock, // Synchronous sample of ext clock
    input  wire        board_rev2,            // Strap, caught after reset
    input  wire        gate_input,
    input  wire        trigger_input,
    output reg  [3:0]  adc_sample_clock,
    output reg         trigger_logic_clock,
    output reg         clock_output,
    output reg         divider_sync_strobe,
    output reg         trigger_output,
    output reg         pll_locked
);
    // ****************************************
    // Helper functions
    // ****************************************
    // Lock test: feedback counts VCXO half periods, so 50 / 5 with 100 locks
    function lock_ok;
        input [15:0] fb;
        input [15:0] rd;
        input [15:0] mhz;
        begin
            lock_ok = (rd != 16'h0000) &&
                      ({16'h0000, fb} * {16'h0000, mhz} ==
                       `VCXO_MHZ * `FB_SCALE * {16'h0000, rd});
        end
    endfunction
    // Divider wrap test shared by the sample and output divider counters
    function wrap;
        input [15:0] cnt;
        input [15:0] div;
        begin
            wrap = (cnt + 16'h0001 >= div);
        end
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    reg        pll_mode;          // Shadow: PLL versus direct drive
    reg        out_enable;        // Shadow: front output buffer
    reg [1:0]  run_mode;          // Acquisition run mode
    reg [15:0] fb_div;            // Shadow dividers
    reg [15:0] ref_div;
    reg [15:0] samp_div;
    reg [15:0] out_div;
    reg [15:0] out_del;
    reg [15:0] ref_mhz;
    reg        act_pll;           // Active copies used by logic
    reg        act_oen;
    reg [15:0] act_fb;
    reg [15:0] act_rd;
    reg [15:0] act_sd;
    reg [15:0] act_od;
    reg [15:0] act_dl;
    reg [15:0] act_mhz;
    reg        load_req;          // Load pending
    reg        sync_req;          // Sync pending after load
    reg        rev_cap;           // Strap captured
    reg        rev2;
    reg        ext_prev;
    reg        gate_prev;
    reg [15:0] samp_cnt;
    reg [15:0] out_cnt;
    reg [15:0] del_cnt;
    reg        samp_int;          // Internal sample clock level
    reg        samp_prev;
    reg [TRIG_LATENCY-1:0] trig_pipe;

    wire wr_en   = psel & penable & pready & pwrite;
    wire ext_rise = shared_external_clock & ~ext_prev;
    wire gate_rise = gate_input & ~gate_prev;
    wire sync_now = divider_sync_strobe;
    wire samp_src = act_pll ? samp_int : shared_external_clock;
    wire samp_rise = samp_src & ~samp_prev & ~(act_pll & ~pll_locked); // Held clocks give no edge

    // ****************************************
    // APB slave
    // ****************************************
    // Answer one cycle into the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= 1'b0;
            if (psel & penable & ~pready) begin
                prdata <= 32'h00000000;
                if (paddr == `OFF_CTRL) begin
                    prdata <= {27'h0000000, load_req, run_mode,
                               out_enable, pll_mode};
                end else if (paddr == `OFF_FBDIV) begin
                    prdata <= {16'h0000, fb_div};
                end else if (paddr == `OFF_REFDIV) begin
                    prdata <= {16'h0000, ref_div};
                end else if (paddr == `OFF_SDIV) begin
                    prdata <= {16'h0000, samp_div};
                end else if (paddr == `OFF_ODIV) begin
                    prdata <= {16'h0000, out_div};
                end else if (paddr == `OFF_ODEL) begin
                    prdata <= {16'h0000, out_del};
                end else if (paddr == `OFF_REFMHZ) begin
                    prdata <= {16'h0000, ref_mhz};
                end else if (paddr == `OFF_STATUS) begin
                    // Live state: lock, source, revision, sync pending
                    prdata <= {27'h0000000, sync_req, rev2,
                               source_select_switch, act_pll, pll_locked};
                end else begin
                    pslverr <= 1'b1; // Unmapped address
                end
            end
        end
    end

    // Writes land at the edge where pready is seen high
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_mode   <= 1'b1;
            out_enable <= 1'b0;
            run_mode   <= 2'h0;
            fb_div     <= `RST_FBDIV;
            ref_div    <= `RST_REFDIV;
            samp_div   <= `RST_SDIV;
            out_div    <= `RST_ODIV;
            out_del    <= `RST_ODEL;
            ref_mhz    <= `RST_REFMHZ;
        end else if (wr_en) begin
            if (paddr == `OFF_CTRL) begin
                pll_mode   <= pwdata[`CTRL_PLL];
                out_enable <= pwdata[`CTRL_OEN];
                run_mode   <= pwdata[`CTRL_RUN_HI:`CTRL_RUN_LO];
            end else if (paddr == `OFF_FBDIV) begin
                fb_div <= pwdata[15:0];
            end else if (paddr == `OFF_REFDIV) begin
                ref_div <= pwdata[15:0];
            end else if (paddr == `OFF_SDIV) begin
                // Below the floor the PLL path would pass 62.5 MHz
                samp_div <= (pwdata[15:0] < `SDIV_MIN) ?
                            `SDIV_MIN : pwdata[15:0];
            end else if (paddr == `OFF_ODIV) begin
                out_div <= pwdata[15:0];
            end else if (paddr == `OFF_ODEL) begin
                out_del <= pwdata[15:0];
            end else if (paddr == `OFF_REFMHZ) begin
                ref_mhz <= pwdata[15:0];
            end
        end
    end

    // ****************************************
    // Configuration load and sync sequencing
    // ****************************************
    // Load copies shadows live; sync follows once copied
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_req <= 1'b1;   // Reset loads defaults, then syncs
            sync_req <= 1'b0;
            act_pll  <= 1'b1;
            act_oen  <= 1'b0;
            act_fb   <= `RST_FBDIV;
            act_rd   <= `RST_REFDIV;
            act_sd   <= `RST_SDIV;
            act_od   <= `RST_ODIV;
            act_dl   <= `RST_ODEL;
            act_mhz  <= `RST_REFMHZ;
        end else begin
            if (load_req) begin
                // Live reload, no power cycle needed
                act_pll  <= pll_mode;
                act_oen  <= out_enable;
                act_fb   <= fb_div;
                act_rd   <= ref_div;
                act_sd   <= samp_div;
                act_od   <= out_div;
                act_dl   <= out_del;
                act_mhz  <= ref_mhz;
                load_req <= 1'b0;
                sync_req <= 1'b1;
            end else if (sync_now) begin
                sync_req <= 1'b0;
            end
            // New load request wins over its own clear
            if (wr_en && paddr == `OFF_CTRL && pwdata[`CTRL_LOAD]) begin
                load_req <= 1'b1;
            end
        end
    end

    // Strap caught once after reset release
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rev_cap <= 1'b0;
            rev2    <= 1'b0;
        end else if (!rev_cap) begin
            rev_cap <= 1'b1;
            rev2    <= board_rev2;
        end
    end

    // Strobe: rev2 waits for an external clock edge so all boards
    // share phase; rev1 in gate mode also pulses on gate leading edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divider_sync_strobe <= 1'b0;
            ext_prev  <= 1'b0;
            gate_prev <= 1'b0;
        end else begin
            ext_prev  <= shared_external_clock;
            gate_prev <= gate_input;
            divider_sync_strobe <= 1'b0;
            if (sync_req && !sync_now && rev_cap && !load_req) begin
                if (!rev2 || ext_rise) begin
                    divider_sync_strobe <= 1'b1;
                end
            end else if (!rev2 && rev_cap && !sync_now && run_mode == `RUN_GATE &&
                         gate_rise) begin
                divider_sync_strobe <= 1'b1;
            end
        end
    end

    // ****************************************
    // Reference, lock and sample clock
    // ****************************************
    // Lock only when the reference lands the VCXO on 500 MHz
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_locked <= 1'b0;
        end else begin
            pll_locked <= act_pll &&
                          lock_ok(act_fb, act_rd, act_mhz);
        end
    end

    // Sample divider; sync forces it to phase zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_cnt <= 16'h0000;
            samp_int <= 1'b0;
        end else if (sync_now || wrap(samp_cnt, act_sd)) begin
            samp_cnt <= 16'h0000;
            samp_int <= 1'b1;
        end else begin
            samp_cnt <= samp_cnt + 16'h0001;
            if (samp_cnt + 16'h0001 >= (act_sd >> 1)) begin
                samp_int <= 1'b0;
            end
        end
    end

    // Four ADC clocks; direct mode follows the external clock
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_sample_clock <= 4'h0;
            samp_prev        <= 1'b0;
        end else begin
            samp_prev <= samp_src & ~(act_pll & ~pll_locked); // Mirrors the ADC clock
            if (act_pll && !pll_locked) begin
                adc_sample_clock <= 4'h0;            // Hold while unlocked
            end else begin
                adc_sample_clock <= {4{samp_src}};
            end
        end
    end

    // Trigger clock toggles on each sample rise: half rate
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trigger_logic_clock <= 1'b0;
        end else if (sync_now) begin
            trigger_logic_clock <= 1'b0;
        end else if (samp_rise) begin
            trigger_logic_clock <= ~trigger_logic_clock;
        end
    end

    // ****************************************
    // Front-panel clock output
    // ****************************************
    // Delay counts sample edges after sync, then divider runs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            del_cnt      <= 16'h0000;
            out_cnt      <= 16'h0000;
            clock_output <= 1'b0;
        end else if (sync_now || !act_oen) begin
            del_cnt      <= 16'h0000;
            out_cnt      <= 16'h0000;
            clock_output <= 1'b0;
        end else if (samp_rise) begin
            if (del_cnt < act_dl) begin
                del_cnt <= del_cnt + 16'h0001;
            end else if (wrap(out_cnt, act_od)) begin
                out_cnt      <= 16'h0000;
                clock_output <= 1'b1;
            end else begin
                out_cnt <= out_cnt + 16'h0001;
                if (out_cnt + 16'h0001 >= (act_od >> 1)) begin
                    clock_output <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Trigger daisy chain
    // ****************************************
    // Fixed latency so downstream post-trigger can compensate
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_pipe      <= {TRIG_LATENCY{1'b0}};
            trigger_output <= 1'b0;
        end else begin
            trig_pipe <= {trig_pipe[TRIG_LATENCY-2:0], trigger_input};
            trigger_output <= trig_pipe[TRIG_LATENCY-1];
        end
    end
endmodule
`default_nettype wire

//--- dv/ext_clock_source.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Shared reference and front inputs
// ****************************************
module ext_clock_source #(parameter int HALF = 4) (
    input  wire logic pclk,
    input  wire logic gate_req,
    input  wire logic trig_req,
    output var logic  shared_external_clock,
    output var logic  gate_input,
    output var logic  trigger_input
);
    int cnt; // Half period counter
    initial begin
        shared_external_clock = 1'b0;
        gate_input = 1'b0;
        trigger_input = 1'b0;
        cnt = 0;
    end
    // Free running, so every board sees one phase; period 2*HALF ticks
    always @(posedge pclk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) begin
            shared_external_clock <= !shared_external_clock;
            // Launch only at the reference's rising edge, never between
            if (!shared_external_clock) begin
                gate_input <= gate_req;
                trigger_input <= trig_req;
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/clk_dist_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "clk_dist_defs.vh"
// ****************************************
// Port checks
// ****************************************
module clk_dist_monitor #(parameter int TRIG_LATENCY = 4) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        board_rev2,
    input wire logic        trigger_input,
    input wire logic [3:0]  adc_sample_clock,
    input wire logic        trigger_logic_clock,
    input wire logic        clock_output,
    input wire logic        divider_sync_strobe,
    input wire logic        trigger_output
);
    localparam int DLY = TRIG_LATENCY + 1;
    logic take;     // Transfer completes this edge
    logic out_seen; // Output enable was written once
    assign take = psel && penable && pready;
    // Remember any enable write, loaded or not
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_seen <= 1'b0;
        end else if (take && pwrite && paddr == `OFF_CTRL && pwdata[`CTRL_OEN]) begin
            out_seen <= 1'b1;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_load;
        take && pwrite && paddr == `OFF_CTRL && pwdata[`CTRL_LOAD] && !board_rev2;
    endsequence
    sequence s_strobe;
        ##[1:3] divider_sync_strobe;
    endsequence
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
    a_ready_time: assert property (psel && penable && !pready |=> pready) else $error("ready late");
    a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_strobe_pulse: assert property (divider_sync_strobe |=> !divider_sync_strobe) else $error("long strobe");
    a_load_strobe: assert property (s_load |-> s_strobe) else $error("no strobe after load");
    a_trig_delay: assert property (trigger_output == $past(trigger_input, DLY)) else $error("trigger delay");
    // Sync realigns the trigger clock, so the edge it lands on is exempt
    a_trig_half: assert property ($rose(adc_sample_clock[0]) && !$past(divider_sync_strobe)
        |-> ##[0:1] $changed(trigger_logic_clock)) else $error("trigger clock rate");
    a_adc_same: assert property (adc_sample_clock == {4{adc_sample_clock[0]}}) else $error("adc skew");
    a_out_gated: assert property (clock_output |-> out_seen) else $error("output not enabled");
endmodule
bind clk_dist clk_dist_monitor #(.TRIG_LATENCY(TRIG_LATENCY)) u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .board_rev2(board_rev2),
    .trigger_input(trigger_input), .adc_sample_clock(adc_sample_clock),
    .trigger_logic_clock(trigger_logic_clock), .clock_output(clock_output),
    .divider_sync_strobe(divider_sync_strobe), .trigger_output(trigger_output));
`default_nettype wire

//--- dv/tb_clk_dist.sv
`timescale 1ns/1ns
`default_nettype none
`include "clk_dist_defs.vh"
module tb_clk_dist;
    localparam int LAT = 3; // Shortened chain delay
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, source_select_switch;
    logic shared_external_clock, board_rev2, gate_input, trigger_input, trigger_logic_clock;
    logic clock_output, divider_sync_strobe, trigger_output, pll_locked, gate_req, trig_req;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  adc_sample_clock;
    logic        er;
    int          n_mismatch, check_count, n, r;
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    clk_dist #(.TRIG_LATENCY(LAT)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .source_select_switch(source_select_switch),
        .shared_external_clock(shared_external_clock), .board_rev2(board_rev2),
        .gate_input(gate_input), .trigger_input(trigger_input), .adc_sample_clock(adc_sample_clock),
        .trigger_logic_clock(trigger_logic_clock), .clock_output(clock_output),
        .divider_sync_strobe(divider_sync_strobe), .trigger_output(trigger_output), .pll_locked(pll_locked));
    ext_clock_source u_src (.pclk(pclk), .gate_req(gate_req), .trig_req(trig_req),
        .shared_external_clock(shared_external_clock), .gate_input(gate_input), .trigger_input(trigger_input));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Setup, access, then hold until ready is sampled
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 32);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 32) n_mismatch++;
    endtask
    task automatic wait_strobe(input int lim);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (divider_sync_strobe !== 1'b1 && n < lim);
    endtask
    // Rising edges over 80 ticks
    task automatic rises(input int sel);
        logic p, c;
        @(posedge pclk);
        p = (sel == 2) ? trigger_logic_clock : (sel == 1) ? clock_output : adc_sample_clock[0];
        r = 0;
        repeat (80) begin
            @(posedge pclk);
            c = (sel == 2) ? trigger_logic_clock : (sel == 1) ? clock_output : adc_sample_clock[0];
            if (c === 1'b1 && p === 1'b0) r++;
            p = c;
        end
    endtask
    task automatic t_reset;
        logic [15:0] exp [6];
        exp = '{`RST_FBDIV, `RST_REFDIV, `RST_SDIV, `RST_ODIV, `RST_ODEL, `RST_REFMHZ};
        wait_strobe(8);
        chk({31'h0, n < 8}, 32'h1);
        chk({31'h0, clock_output}, 32'h0);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 12'h004 + 12'(i * 4), 32'h0);
            chk(rd, {16'h0, exp[i]});
        end
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk(rd & 32'h1F, 32'h3);
        apb(1'b0, 12'h020, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        $display("reset test done");
    endtask
    task automatic t_lock;
        apb(1'b1, `OFF_REFMHZ, 32'h19);
        apb(1'b1, `OFF_FBDIV, 32'h64);
        apb(1'b1, `OFF_CTRL, 32'h11);
        wait_strobe(10);
        chk({31'h0, n <= 4}, 32'h1);
        rises(1'b0);
        chk({31'h0, pll_locked}, 32'h0);
        chk(r, 32'h0);
        apb(1'b1, `OFF_FBDIV, 32'hC8);
        apb(1'b1, `OFF_SDIV, 32'h4);
        apb(1'b0, `OFF_SDIV, 32'h0);
        chk(rd, 32'h8);
        apb(1'b1, `OFF_CTRL, 32'h11);
        wait_strobe(10);
        @(posedge pclk);
        rises(0);
        chk({31'h0, pll_locked}, 32'h1);
        chk(r, 32'hA);
        rises(2);
        chk(r, 32'h5);
        $display("lock test done");
    endtask
    task automatic t_gate;
        apb(1'b1, `OFF_CTRL, 32'h15);
        wait_strobe(10);
        gate_req <= 1'b1;
        wait_strobe(40);
        chk({31'h0, n < 40}, 32'h1);
        gate_req <= 1'b0;
        apb(1'b1, `OFF_CTRL, 32'h11);
        wait_strobe(10);
        repeat (20) @(posedge pclk);
        gate_req <= 1'b1;
        wait_strobe(40);
        chk(n, 32'd40);
        gate_req <= 1'b0;
        $display("gate test done");
    endtask
    task automatic t_trig;
        trig_req <= 1'b1;
        repeat (20) if (trigger_input !== 1'b1) @(posedge pclk);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (trigger_output !== 1'b1 && n < 20);
        chk(n, LAT + 1);
        trig_req <= 1'b0;
        $display("trigger test done");
    endtask
    task automatic t_out;
        apb(1'b1, `OFF_CTRL, 32'h13);
        wait_strobe(10);
        rises(1'b1);
        chk({31'h0, r > 0}, 32'h1);
        source_select_switch <= 1'b1;
        apb(1'b1, `OFF_CTRL, 32'h10);
        wait_strobe(10);
        rises(1'b0);
        chk(r, 32'hA);
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk(rd & 32'hE, 32'h4);
        $display("output test done");
    endtask
    // Second reset with the strap high: the strobe waits for a reference rise
    task automatic t_rev2;
        presetn <= 1'b0;
        board_rev2 <= 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        wait_strobe(16);
        chk({31'h0, n < 16}, 32'h1);
        chk({31'h0, shared_external_clock}, 32'h1);
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk(rd & 32'h8, 32'h8);
        $display("revision test done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, source_select_switch, board_rev2, gate_req, trig_req} = 8'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        n_mismatch = 0;
        check_count = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_lock;
        t_gate;
        t_trig;
        t_out;
        t_rev2;
        close_out;
    end
    // Hang guard, far beyond the several hundred ticks needed
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        close_out;
    end
endmodule
`default_nettype wire
